// ===== logic/rx_lane_debug_status_regs.sv
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
module rx_lane_debug_status_regs
	import rx_lane_status_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [7:0] lane_rx_buffer_empty,
	input wire logic [7:0] lane_rx_buffer_full,
	input wire logic [7:0] lane_word_aligned,
	input wire logic [7:0] lane_calibration_running,
	input wire logic [7:0] lane_recovery_data_locked,
	output logic irq
);
	lane_flags_s live;
	lane_flags_s held;
	logic [NUM_EVENTS-1:0] events;
	bus_req_s req;
	logic [NUM_EVENTS-1:0] irq_status;
	logic [NUM_EVENTS-1:0] irq_enable;
	logic [NUM_EVENTS-1:0] clear_bits;
	logic [31:0] next_rdata;
	logic wr_en;
	logic wr_clear;

	// Accepted address phase, shared by the read mux and the checks
	function automatic logic take_phase(input logic ready, input logic sel,
		input logic [1:0] trans);
		return ready && sel && (trans == HTRANS_NONSEQ);
	endfunction

	assign live = '{lane_rx_buffer_empty, lane_rx_buffer_full, lane_word_aligned,
		lane_calibration_running, lane_recovery_data_locked};

	lane_flag_sampler sampler (
		.hclk(hclk),
		.hresetn(hresetn),
		.live(live),
		.held(held),
		.events(events)
	);

	// Address phase captured; data phase always completes in one cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			req <= '0;
		end else if (hready) begin
			req.sel <= hsel && (htrans == HTRANS_NONSEQ);
			req.write <= hwrite;
			req.addr <= haddr[11:0];
		end
	end

	assign wr_en = req.sel && req.write && (req.addr == ADDR_IRQ_ENABLE);
	assign wr_clear = req.sel && req.write && (req.addr == ADDR_IRQ_CLEAR);
	assign clear_bits = wr_clear ? hwdata[NUM_EVENTS-1:0] : EVENTS_RESET;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_enable <= EVENTS_RESET;
		end else if (wr_en) begin
			irq_enable <= hwdata[NUM_EVENTS-1:0];
		end
	end

	// New event beats a clear landing in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status <= EVENTS_RESET;
		end else begin
			irq_status <= (irq_status & ~clear_bits) | events;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((irq_status & ~clear_bits) | events) & irq_enable);
		end
	end

	// Read data is prepared in the address phase so hrdata leaves a flop
	always_comb begin
		next_rdata = WORD_RESET;
		if (take_phase(hready, hsel, htrans) && !hwrite) begin
			unique case (haddr[11:0])
				ADDR_BUFFER_FLAGS: begin
					next_rdata = pack_pair(held.lane_rx_buffer_empty,
						held.lane_rx_buffer_full);
				end
				ADDR_ALIGN_CALIB_FLAGS: begin
					next_rdata = pack_pair(held.lane_word_aligned,
						held.lane_calibration_running);
				end
				ADDR_CDR_LOCK_FLAGS: begin
					next_rdata = pack_pair(LANES_RESET, held.lane_recovery_data_locked);
				end
				ADDR_IRQ_STATUS: begin
					next_rdata[NUM_EVENTS-1:0] = irq_status;
				end
				ADDR_IRQ_ENABLE: begin
					next_rdata[NUM_EVENTS-1:0] = irq_enable;
				end
				default: begin
					next_rdata = WORD_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= WORD_RESET;
		end else if (hready) begin
			hrdata <= next_rdata;
		end
	end

	sequence rd_req(logic [11:0] a);
		take_phase(hready, hsel, htrans) && !hwrite && (haddr[11:0] == a);
	endsequence

	sequence wr_req(logic [11:0] a);
		take_phase(hready, hsel, htrans) && hwrite && (haddr[11:0] == a);
	endsequence

	// Status words have no write path at all, so writes to them vanish
	status_word_layout_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(hready && hsel && htrans == HTRANS_NONSEQ && !hwrite && haddr[11:0] == ADDR_BUFFER_FLAGS)
		|=> (hrdata[23:16] == $past(held.lane_rx_buffer_empty)) && (hrdata[31:24] == 8'h00))
		else $error("buffer empty field wrong");
	full_field_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(hready && hsel && htrans == HTRANS_NONSEQ && !hwrite && haddr[11:0] == ADDR_BUFFER_FLAGS)
		|=> (hrdata[7:0] == $past(held.lane_rx_buffer_full)) && (hrdata[15:8] == 8'h00))
		else $error("buffer full field wrong");
	align_field_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(hready && hsel && htrans == HTRANS_NONSEQ && !hwrite
		&& haddr[11:0] == ADDR_ALIGN_CALIB_FLAGS)
		|=> hrdata[23:16] == $past(held.lane_word_aligned))
		else $error("alignment field wrong");
	calib_field_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(hready && hsel && htrans == HTRANS_NONSEQ && !hwrite
		&& haddr[11:0] == ADDR_ALIGN_CALIB_FLAGS)
		|=> hrdata[7:0] == $past(held.lane_calibration_running))
		else $error("calibration field wrong");
	lock_field_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(hready && hsel && htrans == HTRANS_NONSEQ && !hwrite && haddr[11:0] == ADDR_CDR_LOCK_FLAGS)
		|=> (hrdata[7:0] == $past(held.lane_recovery_data_locked)) && (hrdata[31:8] == 24'h0))
		else $error("lock field wrong");
	live_mirror_a: assert property (@(posedge hclk) disable iff (!hresetn)
		##1 held == $past(live, 1))
		else $error("held flags not tracking lanes");
	unmapped_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(hready && hsel && htrans == HTRANS_NONSEQ && haddr[11:0] > ADDR_IRQ_CLEAR)
		|=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
		irq == $past(|(((irq_status & ~clear_bits) | events) & irq_enable)) && (hresp == 1'b0))
		else $error("interrupt level wrong");

	// Each interrupt bit records one kind of lane flag edge and stays until cleared
	empty_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
		|(lane_rx_buffer_empty & ~held.lane_rx_buffer_empty)
		|=> ##1 irq_status[EV_EMPTY])
		else $error("empty rise not recorded");

	full_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
		|(lane_rx_buffer_full & ~held.lane_rx_buffer_full)
		|=> ##1 irq_status[EV_FULL])
		else $error("full rise not recorded");

	align_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
		|(held.lane_word_aligned & ~lane_word_aligned)
		|=> ##1 irq_status[EV_ALIGN_LOST])
		else $error("alignment loss not recorded");

	calib_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
		|(held.lane_calibration_running & ~lane_calibration_running)
		|=> ##1 irq_status[EV_CALIB_DONE])
		else $error("calibration end not recorded");

	lock_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
		|(held.lane_recovery_data_locked & ~lane_recovery_data_locked)
		|=> ##1 irq_status[EV_LOCK_LOST])
		else $error("lock loss not recorded");

	events_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
		$stable(held)
		|-> events == EVENTS_RESET)
		else $error("event without a flag change");

	status_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1
		|=> (irq_status & $past(irq_status & ~clear_bits))
		== $past(irq_status & ~clear_bits))
		else $error("status bit lost without clear");

	set_wins_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(events != EVENTS_RESET)
		|=> (irq_status & $past(events)) == $past(events))
		else $error("event not recorded");

	no_stray_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(events == EVENTS_RESET)
		|=> (irq_status & ~$past(irq_status)) == EVENTS_RESET)
		else $error("status set without event");

	clear_lands_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_req(ADDR_IRQ_CLEAR) ##1 (hready && (events == EVENTS_RESET))
		|=> (irq_status & $past(hwdata[NUM_EVENTS-1:0])) == EVENTS_RESET)
		else $error("clear did not land");

	clear_only_ones_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_req(ADDR_IRQ_CLEAR) ##1 hready
		|=> (irq_status & $past(irq_status & ~hwdata[NUM_EVENTS-1:0]))
		== $past(irq_status & ~hwdata[NUM_EVENTS-1:0]))
		else $error("clear hit a zero bit");

	clear_scope_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!wr_clear
		|-> clear_bits == EVENTS_RESET)
		else $error("clear outside clear write");

	strobe_exclusive_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_en
		|-> !wr_clear)
		else $error("two write strobes at once");

	enable_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_req(ADDR_IRQ_ENABLE) ##1 hready
		|=> irq_enable == $past(hwdata[NUM_EVENTS-1:0]))
		else $error("enable write lost");

	enable_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!wr_en
		|=> $stable(irq_enable))
		else $error("enable changed without write");

	enable_clear_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_req(ADDR_IRQ_CLEAR) ##1 hready
		|=> $stable(irq_enable))
		else $error("clear write touched enable");

	ro_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(take_phase(hready, hsel, htrans) && hwrite && (haddr[11:0] <= ADDR_IRQ_STATUS))
		##1 hready
		|=> $stable(irq_enable))
		else $error("status word write had an effect");

	ro_clear_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(take_phase(hready, hsel, htrans) && hwrite && (haddr[11:0] <= ADDR_IRQ_STATUS))
		##1 (hready && (events == EVENTS_RESET))
		|=> irq_status == $past(irq_status))
		else $error("status word write cleared status");

	unmapped_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(take_phase(hready, hsel, htrans) && hwrite && (haddr[11:0] > ADDR_IRQ_CLEAR))
		##1 hready
		|=> $stable(irq_enable))
		else $error("unmapped write had an effect");

	write_rdata_a: assert property (@(posedge hclk) disable iff (!hresetn)
		take_phase(hready, hsel, htrans) && hwrite
		|=> hrdata == WORD_RESET)
		else $error("write returned data");

	status_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_req(ADDR_IRQ_STATUS)
		|=> hrdata == {{(32 - NUM_EVENTS){1'b0}}, $past(irq_status)})
		else $error("status read wrong");

	enable_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_req(ADDR_IRQ_ENABLE)
		|=> hrdata == {{(32 - NUM_EVENTS){1'b0}}, $past(irq_enable)})
		else $error("enable read wrong");

	clear_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_req(ADDR_IRQ_CLEAR)
		|=> hrdata == WORD_RESET)
		else $error("clear register read not zero");

	align_gaps_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_req(ADDR_ALIGN_CALIB_FLAGS)
		|=> (hrdata[31:24] == 8'h00) && (hrdata[15:8] == 8'h00))
		else $error("second word gap not zero");

	gap_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
		take_phase(hready, hsel, htrans) && !hwrite && (haddr[1:0] != 2'h0)
		|=> hrdata == WORD_RESET)
		else $error("unaligned read not zero");

	idle_rdata_a: assert property (@(posedge hclk) disable iff (!hresetn)
		hready && !take_phase(hready, hsel, htrans)
		|=> hrdata == WORD_RESET)
		else $error("idle read data not zero");

	req_capture_a: assert property (@(posedge hclk) disable iff (!hresetn)
		take_phase(hready, hsel, htrans)
		|=> req.sel && (req.write == $past(hwrite))
		&& (req.addr == $past(haddr[11:0])))
		else $error("address phase not captured");

	req_idle_a: assert property (@(posedge hclk) disable iff (!hresetn)
		hready && !take_phase(hready, hsel, htrans)
		|=> !req.sel)
		else $error("idle cycle captured as transfer");

	okay_resp_a: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1
		|-> hreadyout && !hresp)
		else $error("slave not ready or not okay");

	irq_masked_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(irq_enable == EVENTS_RESET)
		|=> !irq)
		else $error("masked interrupt raised");

	irq_raise_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(|(irq_status & irq_enable)) && (clear_bits == EVENTS_RESET)
		|=> irq)
		else $error("enabled status did not raise interrupt");

	irq_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
		((((irq_status & ~clear_bits) | events) & irq_enable) == EVENTS_RESET)
		|=> !irq)
		else $error("interrupt stayed without cause");

	reset_values_a: assert property (@(posedge hclk)
		!hresetn ##1 !hresetn
		|-> (hrdata == WORD_RESET) && !irq && (irq_status == EVENTS_RESET)
		&& (irq_enable == EVENTS_RESET) && (held == '0) && hreadyout && !hresp)
		else $error("reset value wrong");
endmodule

// ===== logic/rx_lane_status_pkg.sv
// Contract
// - First word bits 23:16 show per-lane receive buffer empty, lane 7 highest.
// - First word bits 7:0 show per-lane receive buffer full, lane 7 in bit 7.
// - Second word bits 23:16 show per-lane word boundary found and aligned.
// - Second word bits 7:0 show per-lane calibration still running.
// - Third word bits 7:0 show per-lane recovery loop locked to data.
// - All three words are read-only live monitors; every field resets to zero.
package rx_lane_status_pkg;
	localparam int NUM_LANES = 8;
	localparam logic [11:0] ADDR_BUFFER_FLAGS = 12'h000;
	localparam logic [11:0] ADDR_ALIGN_CALIB_FLAGS = 12'h004;
	localparam logic [11:0] ADDR_CDR_LOCK_FLAGS = 12'h008;
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h00C;
	localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h010;
	localparam logic [11:0] ADDR_IRQ_CLEAR = 12'h014;
	localparam int HI_FIELD_LSB = 16;
	localparam int LO_FIELD_LSB = 0;
	localparam logic [31:0] WORD_RESET = 32'h0000_0000;
	localparam logic [7:0] LANES_RESET = 8'h00;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	// Interrupt event bits: rising edge of the empty and full groups, falling edge of the alignment, calibration and lock groups
	localparam int EV_EMPTY = 0;
	localparam int EV_FULL = 1;
	localparam int EV_ALIGN_LOST = 2;
	localparam int EV_CALIB_DONE = 3;
	localparam int EV_LOCK_LOST = 4;
	localparam int NUM_EVENTS = 5;
	localparam logic [4:0] EVENTS_RESET = 5'h00;

	typedef struct packed {
		logic [7:0] lane_rx_buffer_empty;
		logic [7:0] lane_rx_buffer_full;
		logic [7:0] lane_word_aligned;
		logic [7:0] lane_calibration_running;
		logic [7:0] lane_recovery_data_locked;
	} lane_flags_s;

	typedef struct packed {
		logic sel;
		logic write;
		logic [11:0] addr;
	} bus_req_s;

	function automatic logic [31:0] pack_pair(input logic [7:0] hi, input logic [7:0] lo);
		logic [31:0] w;
		w = WORD_RESET;
		w[HI_FIELD_LSB +: 8] = hi;
		w[LO_FIELD_LSB +: 8] = lo;
		return w;
	endfunction
endpackage

// ===== logic/lane_flag_sampler.sv
`timescale 1ns/1ps
module lane_flag_sampler
	import rx_lane_status_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire lane_flags_s live,
	output lane_flags_s held,
	output logic [NUM_EVENTS-1:0] events
);
	lane_flags_s prev;

	// Registered copy keeps the read mux off the transceiver nets
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			held <= '0;
		end else begin
			held <= live;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prev <= '0;
		end else begin
			prev <= held;
		end
	end

	always_comb begin
		events = EVENTS_RESET;
		events[EV_EMPTY] = |(held.lane_rx_buffer_empty & ~prev.lane_rx_buffer_empty);
		events[EV_FULL] = |(held.lane_rx_buffer_full & ~prev.lane_rx_buffer_full);
		events[EV_ALIGN_LOST] = |(prev.lane_word_aligned & ~held.lane_word_aligned);
		events[EV_CALIB_DONE] = |(prev.lane_calibration_running & ~held.lane_calibration_running);
		events[EV_LOCK_LOST] = |(prev.lane_recovery_data_locked & ~held.lane_recovery_data_locked);
	end
endmodule

// ===== verif/tb_rx_lane_debug_status_regs.sv
`timescale 1ns/1ps
module tb_rx_lane_debug_status_regs
	import rx_lane_status_pkg::*;
;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic rd_phase = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = HSIZE_WORD;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic irq;
	lane_flags_s lanes = '0;
	logic [63:0] r;
	logic [31:0] q[$];
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;
	integer seed = 32'hBEF0E6E3;

	rx_lane_debug_status_regs i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.lane_rx_buffer_empty(lanes.lane_rx_buffer_empty),
		.lane_rx_buffer_full(lanes.lane_rx_buffer_full),
		.lane_word_aligned(lanes.lane_word_aligned),
		.lane_calibration_running(lanes.lane_calibration_running),
		.lane_recovery_data_locked(lanes.lane_recovery_data_locked), .irq(irq));

	initial begin
		forever #2 hclk = ~hclk;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_sim();
		$display("mismatches %0d n_tests %0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// One single AHB transfer; a read notes its expected word for the monitor
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		if (!w) begin
			q.push_back(d);
		end
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {20'h0, a};
		hwrite <= w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= w ? d : 32'h0;
		rd_phase <= !w;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd_phase <= 1'b0;
	endtask

	// Data phase ends at this edge; hrdata still holds the pre-edge value
	always @(posedge hclk) begin
		if (rd_phase && hreadyout === 1'b1 && q.size() > 0) begin
			check(hrdata, q.pop_front());
			check({31'h0, hresp}, 32'h0);
		end
	end

	always @(posedge hclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			end_sim();
		end
	end

	initial begin
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		check(hrdata, WORD_RESET);
		check({30'h0, hreadyout, hresp}, 32'h2);
		for (int i = 0; i < 6; i++) xfer(1'b0, 12'(i * 4), WORD_RESET);
		xfer(1'b0, 12'h020, 32'h0);
		xfer(1'b1, 12'h020, 32'h1F);
		xfer(1'b0, ADDR_IRQ_ENABLE, 32'h0);
		xfer(1'b1, ADDR_IRQ_ENABLE, 32'h1);
		lanes.lane_rx_buffer_empty <= 8'h01;
		repeat (4) @(posedge hclk);
		check({31'h0, irq}, 32'h1);
		xfer(1'b0, ADDR_IRQ_STATUS, 32'h1 << EV_EMPTY);
		xfer(1'b1, ADDR_IRQ_CLEAR, 32'h1);
		repeat (3) @(posedge hclk);
		check({31'h0, irq}, 32'h0);
		xfer(1'b0, ADDR_IRQ_STATUS, 32'h0);
		xfer(1'b1, ADDR_IRQ_ENABLE, 32'h0);
		lanes.lane_rx_buffer_full <= 8'h80;
		repeat (4) @(posedge hclk);
		// Masked event is still recorded but must not raise the line
		check({31'h0, irq}, 32'h0);
		xfer(1'b0, ADDR_IRQ_STATUS, 32'h1 << EV_FULL);
		xfer(1'b1, ADDR_IRQ_CLEAR, 32'h1F);
		for (int k = 0; k < 24; k++) begin
			r = {$random(seed), $random(seed)};
			lanes <= r[39:0];
			repeat (2) @(posedge hclk);
			xfer(1'b1, 12'(4 * (k % 3)), $random(seed));
			xfer(1'b0, ADDR_BUFFER_FLAGS, {8'h0, lanes.lane_rx_buffer_empty, 8'h0,
				lanes.lane_rx_buffer_full});
			xfer(1'b0, ADDR_ALIGN_CALIB_FLAGS, {8'h0, lanes.lane_word_aligned, 8'h0,
				lanes.lane_calibration_running});
			xfer(1'b0, ADDR_CDR_LOCK_FLAGS, {24'h0, lanes.lane_recovery_data_locked});
		end
		// Falling groups: alignment, calibration and lock events together
		lanes <= '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF};
		repeat (3) @(posedge hclk);
		xfer(1'b1, ADDR_IRQ_CLEAR, 32'h1F);
		xfer(1'b1, ADDR_IRQ_ENABLE, 32'h1C);
		lanes <= '0;
		repeat (4) @(posedge hclk);
		check({31'h0, irq}, 32'h1);
		xfer(1'b0, ADDR_IRQ_ENABLE, 32'h1C);
		xfer(1'b0, ADDR_IRQ_STATUS, 32'h1C);
		// Mid-run reset wipes status and enable
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		check({31'h0, irq}, 32'h0);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(1'b0, ADDR_IRQ_STATUS, 32'h0);
		xfer(1'b0, ADDR_IRQ_ENABLE, 32'h0);
		xfer(1'b0, ADDR_BUFFER_FLAGS, WORD_RESET);
		repeat (2) @(posedge hclk);
		end_sim();
	end
endmodule
